// file: core/rxst_pkg.sv
// Shared constants and carrier types for the receive self-test status block
package rxst_pkg;

  // ******************************
  // Timing
  // ******************************
  // Least error pulse, in recovered clock cycles
  localparam int unsigned ERR_MIN_CYC = 3;
  localparam logic [1:0] ERR_CNT_INIT = 2'(ERR_MIN_CYC - 1);

  // ******************************
  // Modes and carriers
  // ******************************
  // Mode select encoding: 0 = incrementing pattern, 1 = pseudo-random
  localparam logic MODE_INCR = 1'b0;
  localparam logic MODE_PRBS = 1'b1;

  // One cycle's report from the pattern checker
  typedef struct packed {
    logic cycle_done;
    logic err_seen;
  } rxst_event_s;

  // Status flags handed to the fabric
  typedef struct packed {
    logic done;
    logic err;
  } rxst_flags_s;

endpackage : rxst_pkg

// file: core/rxst_status.sv
// Receive self-test verifier status flags and calibration block power gate
`timescale 1ns/100ps

// How it works
// - Incrementing mode: done on cycle or error, sticky
// - Pseudo-random mode: done only on full cycle
// - Incrementing mode: error flag sticky until reset
// - Pseudo-random mode: error pulse at least three cycles
// - Pseudo-random mode: clean sequence clears error flag
// - Calibration clock in, held idle while powered down
// - Receiver digital reset clears everything, one cycle
module rxst_status (
  // Clock and receiver digital reset
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // Verifier configuration and checker events
  input wire logic TEST_MODE,
  input wire rxst_pkg::rxst_event_s CHK_EVENT,
  // Calibration block clock and power down
  input wire logic CAL_CLK,
  input wire logic CAL_POWERDOWN,
  // Status to fabric
  output logic TEST_DONE,
  output logic TEST_ERR,
  output logic CAL_ACTIVE
);

  // ******************************
  // Pin synchronisers
  // ******************************
  // Three stages; a change counts once the last two agree
  logic [2:0] pd_sync_reg, pd_sync_next;
  logic [2:0] cck_sync_reg, cck_sync_next;
  logic pd_reg, pd_next;
  logic cck_reg, cck_next;

  always_comb begin
    pd_sync_next = {pd_sync_reg[1:0], CAL_POWERDOWN};
    cck_sync_next = {cck_sync_reg[1:0], CAL_CLK};
    pd_next = (pd_sync_reg[2] == pd_sync_reg[1]) ? pd_sync_reg[2] : pd_reg;
    cck_next = (cck_sync_reg[2] == cck_sync_reg[1]) ? cck_sync_reg[2] : cck_reg;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      pd_sync_reg <= 3'h7;
      cck_sync_reg <= 3'h0;
      pd_reg <= 1'b1;
      cck_reg <= 1'b0;
    end else begin
      pd_sync_reg <= pd_sync_next;
      cck_sync_reg <= cck_sync_next;
      pd_reg <= pd_next;
      cck_reg <= cck_next;
    end
  end

  // ******************************
  // Calibration block
  // ******************************
  // Goes active on a clock toggle while powered up and stays active until power down;
  // a clock that never toggles leaves the block idle unless it sits high as reset ends while powered up, but one that stops later does not
  logic cck_prev_reg, cck_prev_next;
  logic cal_active_reg, cal_active_next;

  always_comb begin
    cck_prev_next = cck_reg;
    cal_active_next = cal_active_reg;
    if (pd_reg) begin
      cal_active_next = 1'b0;
    end else if (cck_reg != cck_prev_reg) begin
      cal_active_next = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      cck_prev_reg <= 1'b0;
      cal_active_reg <= 1'b0;
    end else begin
      cck_prev_reg <= cck_prev_next;
      cal_active_reg <= cal_active_next;
    end
  end

  // ******************************
  // Verifier status
  // ******************************
  typedef enum logic [1:0] {RXST_IDLE, RXST_PULSE, RXST_HOLD} rxst_err_e;

  rxst_err_e err_st_reg, err_st_next;
  rxst_pkg::rxst_flags_s flags_reg, flags_next;
  logic [1:0] err_cnt_reg, err_cnt_next;
  logic prbs;

  always_comb begin
    prbs = (TEST_MODE == rxst_pkg::MODE_PRBS);
    flags_next = flags_reg;
    err_st_next = err_st_reg;
    err_cnt_next = err_cnt_reg;
    if (!prbs) begin
      if (CHK_EVENT.cycle_done || CHK_EVENT.err_seen) begin
        flags_next.done = 1'b1;
      end
      if (CHK_EVENT.err_seen) begin
        flags_next.err = 1'b1;
      end
    end else begin
      if (CHK_EVENT.cycle_done) begin
        flags_next.done = 1'b1;
      end
      case (err_st_reg)
        RXST_IDLE: begin
          if (CHK_EVENT.err_seen) begin
            flags_next.err = 1'b1;
            err_cnt_next = rxst_pkg::ERR_CNT_INIT;
            err_st_next = RXST_PULSE;
          end
        end
        RXST_PULSE: begin
          // Fresh errors restart the minimum width
          if (CHK_EVENT.err_seen) begin
            err_cnt_next = rxst_pkg::ERR_CNT_INIT;
          end else if (err_cnt_reg != 2'h0) begin
            err_cnt_next = err_cnt_reg - 2'h1;
          end else begin
            err_st_next = RXST_HOLD;
          end
        end
        RXST_HOLD: begin
          // Clean sequence end drops the flag; an error restarts the pulse
          if (CHK_EVENT.err_seen) begin
            err_cnt_next = rxst_pkg::ERR_CNT_INIT;
            err_st_next = RXST_PULSE;
          end else if (CHK_EVENT.cycle_done) begin
            flags_next.err = 1'b0;
            err_st_next = RXST_IDLE;
          end
        end
        default: begin
          err_st_next = RXST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      flags_reg <= '0;
      err_st_reg <= RXST_IDLE;
      err_cnt_reg <= 2'h0;
    end else begin
      flags_reg <= flags_next;
      err_st_reg <= err_st_next;
      err_cnt_reg <= err_cnt_next;
    end
  end

  // Flags are level outputs; the fabric side must synchronise them
  assign TEST_DONE = flags_reg.done;
  assign TEST_ERR = flags_reg.err;
  assign CAL_ACTIVE = cal_active_reg;

  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_prbs_err;
    prbs && CHK_EVENT.err_seen;
  endsequence

  sequence s_err_held3;
    TEST_ERR [*3];
  endsequence

  // Clean sequence end once the minimum pulse has run out
  sequence s_clean_end;
    prbs && err_st_reg == RXST_HOLD && CHK_EVENT.cycle_done && !CHK_EVENT.err_seen;
  endsequence

  // Completion flag
  chk_incr_done_set: assert property (
    !prbs && (CHK_EVENT.cycle_done || CHK_EVENT.err_seen) |=> TEST_DONE)
    else $error("done not raised in incrementing mode");
  chk_prbs_done_set: assert property (
    prbs && CHK_EVENT.cycle_done |=> TEST_DONE)
    else $error("done not raised on full cycle");
  chk_prbs_done_err: assert property (
    prbs && !TEST_DONE && !CHK_EVENT.cycle_done |=> !TEST_DONE)
    else $error("done raised without full cycle");
  chk_done_sticky: assert property (
    TEST_DONE |=> TEST_DONE)
    else $error("done dropped before reset");

  // Incrementing-mode error flag
  chk_incr_err_sticky: assert property (
    !prbs && TEST_ERR && $stable(TEST_MODE) |=> TEST_ERR)
    else $error("error flag dropped in incrementing mode");
  chk_incr_err_set: assert property (
    !prbs && CHK_EVENT.err_seen |=> TEST_ERR)
    else $error("error flag not raised");
  chk_incr_err_only: assert property (
    !prbs && !TEST_ERR && !CHK_EVENT.err_seen |=> !TEST_ERR)
    else $error("error flag raised without error");

  // Pseudo-random error pulse; a clean end inside the pulse must not cut it
  chk_prbs_err_width: assert property (
    s_prbs_err |=> s_err_held3)
    else $error("error pulse shorter than three cycles");
  chk_pulse_err_high: assert property (
    err_st_reg == RXST_PULSE |-> TEST_ERR)
    else $error("error flag low inside minimum pulse");
  chk_prbs_err_keep: assert property (
    prbs && TEST_ERR && !CHK_EVENT.cycle_done |=> TEST_ERR)
    else $error("error flag dropped without clean sequence");
  chk_prbs_err_clear: assert property (
    s_clean_end |=> !TEST_ERR)
    else $error("error not cleared");

  // Calibration block
  chk_cal_pd_off: assert property (
    pd_reg |=> !CAL_ACTIVE)
    else $error("calibration active while powered down");
  chk_cal_wake: assert property (
    !pd_reg && cck_reg != cck_prev_reg |=> CAL_ACTIVE)
    else $error("calibration not started by its clock");

  // Reset; the default disable would hide these, so it is switched off here
  chk_reset_clear: assert property (
    disable iff (1'b0) !RESET_N |=> !TEST_DONE && !TEST_ERR)
    else $error("flags not cleared by reset");
  chk_reset_cal: assert property (
    disable iff (1'b0) !RESET_N |=> !CAL_ACTIVE)
    else $error("calibration not stopped by reset");

endmodule : rxst_status

// file: sim/rxst_fabric_mon.sv
// Fabric-side model: calibration clock source and flag synchroniser
`timescale 1ns/100ps
module rxst_fabric_mon (
  // Receive clock
  input wire logic clk,
  // Flags from the block
  input wire logic done,
  input wire logic err,
  // Calibration clock and synchronised flags
  output logic cal_clk,
  output logic done_sync,
  output logic err_sync
);
  logic [1:0] meta_reg;
  // Free-running; offset so no toggle meets a receive clock edge,
  // and slow enough that the pin filter sees two equal samples
  initial begin
    cal_clk = 1'b0;
    #2;
    forever #20 cal_clk = ~cal_clk;
  end
  // Two stages, flags are asynchronous to the fabric
  always_ff @(posedge clk) begin
    meta_reg <= {done, err};
    {done_sync, err_sync} <= meta_reg;
  end
endmodule : rxst_fabric_mon

// file: sim/rxst_status_tb.sv
// Self-checking bench for the receive self-test status block
`timescale 1ns/100ps
module rxst_status_tb;
  logic clk;
  logic rst_n = 1'b0;
  logic mode = 1'b0;
  logic cal_pd = 1'b1;
  rxst_pkg::rxst_event_s ev = '0;
  logic cal_clk, done, err, cal_act, done_s, err_s;
  int err_total = 0;
  int checks_done = 0;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  rxst_status rxst_status_inst (.SYS_CLK(clk), .RESET_N(rst_n), .TEST_MODE(mode),
    .CHK_EVENT(ev), .CAL_CLK(cal_clk), .CAL_POWERDOWN(cal_pd), .TEST_DONE(done),
    .TEST_ERR(err), .CAL_ACTIVE(cal_act));
  rxst_fabric_mon rxst_fabric_mon_inst (.clk(clk), .done(done), .err(err),
    .cal_clk(cal_clk), .done_sync(done_s), .err_sync(err_s));
  // ********************
  // Helpers
  // ********************
  task chk(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %b want %b", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task fire(input logic cd, input logic es);
    @(posedge clk);
    ev <= '{cycle_done: cd, err_seen: es};
    @(posedge clk);
    ev <= '0;
    #1;
  endtask : fire
  task rst();
    @(posedge clk);
    rst_n <= 1'b0; // Two-edge minimum pulse
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(done, 1'b0);
    chk(err, 1'b0);
  endtask : rst
  task conclude();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ********************
  // Scenarios
  // ********************
  task t_incr();
    fire(1'b0, 1'b1);
    cyc(2);
    chk(done, 1'b1);
    fire(1'b1, 1'b0);
    cyc(2);
    chk(err, 1'b1);
    chk(err_s, 1'b1);
    rst();
    fire(1'b1, 1'b0);
    cyc(5);
    chk(done, 1'b1);
    chk(err, 1'b0);
    chk(done_s, 1'b1);
    chk(err_s, 1'b0);
    rst();
  endtask : t_incr
  task t_prbs();
    @(posedge clk);
    mode <= 1'b1;
    fire(1'b0, 1'b1);
    chk(err, 1'b1);
    cyc(1);
    chk(err, 1'b1);
    cyc(1);
    chk(err, 1'b1);
    chk(done, 1'b0);
    cyc(4);
    chk(err, 1'b1);
    fire(1'b0, 1'b1);
    cyc(5);
    fire(1'b1, 1'b0);
    cyc(2);
    chk(err, 1'b0);
    chk(done, 1'b1);
    fire(1'b0, 1'b1);
    fire(1'b1, 1'b0);
    chk(err, 1'b1);
    rst();
  endtask : t_prbs
  // Synchroniser latency is a few cycles, so waits are generous
  task t_cal();
    chk(cal_act, 1'b0);
    @(posedge clk);
    cal_pd <= 1'b0;
    cyc(16);
    chk(cal_act, 1'b1);
    @(posedge clk);
    cal_pd <= 1'b1;
    cyc(10);
    chk(cal_act, 1'b0);
  endtask : t_cal
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    t_incr();
    t_prbs();
    t_cal();
    conclude();
  end
  initial begin
    #20000;
    err_total++;
    conclude();
  end
endmodule : rxst_status_tb
